/* File: dacrc_top.sv */
// dacrc_top: conversion control and two-strobe parallel readout
// assumes: analog side delivers two raw codes per conversion as straight
// binary offsets; host pins are asynchronous and pass a 3-flop filter
`timescale 1ns/1ps
module dacrc_top #(
    parameter bit BIPOLAR = 1'b1              // 1: twos complement coding
) (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    // host control pins
    input  wire logic        CONVERSION_START_N_IN,
    input  wire logic        INPUT_PAIR_SELECT_IN,
    input  wire logic        CHIP_SELECT_N_IN,
    input  wire logic        READ_N_IN,
    // raw codes from the two converters, straight binary from the bottom of the range
    input  wire logic [13:0] CONVERTER_ONE_RAW_IN,
    input  wire logic [13:0] CONVERTER_TWO_RAW_IN,
    // analog mux control, high routes pair B to both converters
    output logic             MUX_PAIR_B_OUT,
    // host status and data pins
    output logic             BUSY_OUT,
    output logic             TRACK_HOLD_OUT,
    output logic [13:0]      DATA_OUT,
    output logic             DATA_OE_OUT,
    output logic             FIFO_OVERFLOW_OUT
);
    // ------------------------------------------------------------------
    // types and declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_PUSH} dacrc_state_type;
    localparam int unsigned CW = $clog2(dacrc_pkg::CONV_CYCLES + 1);

    logic [2:0]  start_sync;                  // start pin filter
    logic [2:0]  pair_sync;                   // pair select filter
    logic [2:0]  cs_sync;                     // chip select filter
    logic [2:0]  rd_sync;                     // read strobe filter
    logic        start_n;                     // filtered start level
    logic        pair_sel;                    // filtered pair select
    logic        cs_n;                        // filtered chip select
    logic        rd_n;                        // filtered read strobe
    logic        next_start_n, next_pair_sel, next_cs_n, next_rd_n;

    dacrc_state_type          state, next_state;
    logic [CW-1:0]            conv_cnt, next_conv_cnt;     // conversion timer
    dacrc_pkg::dacrc_sample_type sample, next_sample;      // held conversion
    logic                     busy, next_busy;
    logic                     hold, next_hold;
    logic                     overflow, next_overflow;

    logic                     second_read, next_second_read; // word pointer
    logic [13:0]              data, next_data;
    logic                     data_oe, next_data_oe;
    logic                     have_word, next_have_word;   // popped sample held
    dacrc_pkg::dacrc_sample_type rd_word, next_rd_word;

    logic                     fifo_in_ready;
    logic                     fifo_out_valid;
    logic                     fifo_pop;
    dacrc_pkg::dacrc_sample_type fifo_out;

    // ------------------------------------------------------------------
    // output coding
    // ------------------------------------------------------------------
    // raw code counts from the bottom of the range; bipolar flips the msb
    function automatic logic [13:0] encode(input logic [13:0] raw);
        if (BIPOLAR)
        begin
            // bottom 0000 -> 2000, ground 2000 -> 0000, top 3FFF -> 1FFF
            return {~raw[13], raw[12:0]};
        end
        return raw;
    endfunction : encode

    // ------------------------------------------------------------------
    // pin filters: three flops, a change counts when last two agree
    // ------------------------------------------------------------------
    always_comb
    begin
        next_start_n  = (start_sync[2] == start_sync[1]) ? start_sync[2] : start_n;
        next_pair_sel = (pair_sync[2] == pair_sync[1]) ? pair_sync[2] : pair_sel;
        next_cs_n     = (cs_sync[2] == cs_sync[1]) ? cs_sync[2] : cs_n;
        next_rd_n     = (rd_sync[2] == rd_sync[1]) ? rd_sync[2] : rd_n;
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            start_sync <= 3'h7;
            pair_sync  <= 3'h0;
            cs_sync    <= 3'h7;
            rd_sync    <= 3'h7;
            start_n    <= 1'b1;
            pair_sel   <= 1'b0;
            cs_n       <= 1'b1;
            rd_n       <= 1'b1;
        end
        else
        begin
            start_sync <= {start_sync[1:0], CONVERSION_START_N_IN};
            pair_sync  <= {pair_sync[1:0], INPUT_PAIR_SELECT_IN};
            cs_sync    <= {cs_sync[1:0], CHIP_SELECT_N_IN};
            rd_sync    <= {rd_sync[1:0], READ_N_IN};
            start_n    <= next_start_n;
            pair_sel   <= next_pair_sel;
            cs_n       <= next_cs_n;
            rd_n       <= next_rd_n;
        end
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state    = state;
        next_conv_cnt = conv_cnt;
        next_sample   = sample;
        next_busy     = busy;
        next_hold     = hold;
        next_overflow = overflow;
        case (state)
            ST_IDLE:
            begin
                // mux tracks the select while idle, frozen once holding
                next_sample.pair_b = pair_sel;
                // start edge: both holds close together, busy rises
                if (start_n && !next_start_n)
                begin
                    next_hold          = 1'b1;
                    next_busy          = 1'b1;
                    next_conv_cnt      = CW'(dacrc_pkg::CONV_LOAD);
                    next_state         = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                // internal timer paces the conversion
                if (conv_cnt == '0)
                begin
                    next_sample.input_one = encode(CONVERTER_ONE_RAW_IN);
                    next_sample.input_two = encode(CONVERTER_TWO_RAW_IN);
                    next_state            = ST_PUSH;
                end
                else
                begin
                    next_conv_cnt = conv_cnt - 1'b1;
                end
            end
            ST_PUSH:
            begin
                // write to output queue and release busy and track on the same edge
                next_hold  = 1'b0;
                next_busy  = 1'b0;
                next_state = ST_IDLE;
                if (!fifo_in_ready)
                begin
                    next_overflow = 1'b1;     // oldest unread sample kept
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            state    <= ST_IDLE;
            conv_cnt <= '0;
            sample   <= '0;
            busy     <= 1'b0;
            hold     <= 1'b0;
            overflow <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            conv_cnt <= next_conv_cnt;
            sample   <= next_sample;
            busy     <= next_busy;
            hold     <= next_hold;
            overflow <= next_overflow;
        end
    end

    // ------------------------------------------------------------------
    // result queue
    // ------------------------------------------------------------------
    dacrc_fifo #(
        .WIDTH ($bits(dacrc_pkg::dacrc_sample_type)),
        .DEPTH (dacrc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (CLK_IN),
        .rst_in        (SYS_RST_IN),
        .in_valid_in   (state == ST_PUSH),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (sample),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out)
    );

    // ------------------------------------------------------------------
    // read port: first strobe input one, second input two
    // ------------------------------------------------------------------
    always_comb
    begin
        next_second_read = second_read;
        next_data        = data;
        next_data_oe     = !cs_n && !rd_n;
        next_have_word   = have_word;
        next_rd_word     = rd_word;
        fifo_pop         = 1'b0;
        // fetch next queued sample whenever none is held
        if (!have_word && fifo_out_valid)
        begin
            fifo_pop       = 1'b1;
            next_rd_word   = fifo_out;
            next_have_word = 1'b1;
        end
        // strobe start: drive the word for this slot; with no sample held, data keeps last word
        if (!cs_n && rd_n && !next_rd_n && have_word)
        begin
            next_data = second_read ? rd_word.input_two : rd_word.input_one;
        end
        // strobe end: advance word pointer, drop sample after pair
        if (!cs_n && !rd_n && next_rd_n)
        begin
            next_second_read = !second_read;
            if (second_read && have_word)
            begin
                next_have_word = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            second_read <= 1'b0;
            data        <= dacrc_pkg::RESET_RESULT;
            data_oe     <= 1'b0;
            have_word   <= 1'b0;
            rd_word     <= '0;
        end
        else
        begin
            second_read <= next_second_read;
            data        <= next_data;
            data_oe     <= next_data_oe;
            have_word   <= next_have_word;
            rd_word     <= next_rd_word;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from flops
    // ------------------------------------------------------------------
    always_comb
    begin
        BUSY_OUT          = busy;
        TRACK_HOLD_OUT    = hold;
        DATA_OUT          = data;
        DATA_OE_OUT       = data_oe;
        FIFO_OVERFLOW_OUT = overflow;
        MUX_PAIR_B_OUT    = sample.pair_b;
    end
endmodule : dacrc_top

/* File: dacrc_pkg.sv */
// dacrc_pkg: shared constants and types for the dual converter control block
// assumes: a single 125 MHz clock domain; no imports, every use is scoped
package dacrc_pkg;
    // ------------------------------------------------------------------
    // data widths
    // ------------------------------------------------------------------
    localparam int unsigned RESULT_WIDTH  = 14;       // result word width
    localparam int unsigned FIFO_DEPTH    = 16;       // words buffered
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 8000;     // 125 MHz clock
    localparam int unsigned CONV_TIME_NS  = 5200;     // longest conversion
    // longest time rounds down to whole cycles
    localparam int unsigned CONV_CYCLES   = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    // worst pin edge to busy rise: one cycle to sample, three filter flops
    localparam int unsigned PIN_LATENCY   = 4;
    // timer load; busy stands load plus two cycles, so pin to done fits the limit
    localparam int unsigned CONV_LOAD     = CONV_CYCLES - PIN_LATENCY - 2;
    // ------------------------------------------------------------------
    // codes
    // ------------------------------------------------------------------
    localparam logic [13:0] BIPOLAR_MIN   = 14'h2000; // most negative code
    localparam logic [13:0] BIPOLAR_MAX   = 14'h1FFF; // most positive code
    localparam logic [13:0] UNIPOLAR_MAX  = 14'h3FFF; // all ones
    localparam logic [13:0] RESET_RESULT  = 14'h0000; // result after reset
    // ------------------------------------------------------------------
    // one conversion: pair used and both codes
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        pair_b;                          // pair select at start
        logic [13:0] input_one;                       // first converter code
        logic [13:0] input_two;                       // second converter code
    } dacrc_sample_type;
endpackage : dacrc_pkg

/* File: dacrc_fifo.sv */
// dacrc_fifo: synchronous FIFO with valid/ready on both sides
// assumes: one clock, asynchronous active-high reset
`timescale 1ns/1ps
module dacrc_fifo #(
    parameter int unsigned WIDTH = 29,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];            // storage
    logic [AW-1:0]    wr_ptr;                 // write index
    logic [AW-1:0]    rd_ptr;                 // read index
    logic [AW:0]      count;                  // words held
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             do_wr;                  // accepted write
    logic             do_rd;                  // accepted read

    // ------------------------------------------------------------------
    // handshake and next pointers
    // ------------------------------------------------------------------
    always_comb
    begin
        in_ready_out  = (count != DEPTH[AW:0]);
        out_valid_out = (count != '0);
        out_data_out  = mem[rd_ptr];
        do_wr         = in_valid_in && in_ready_out;
        do_rd         = out_valid_out && out_ready_in;
        next_wr_ptr   = do_wr ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr   = do_rd ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count    = count;
        if (do_wr && !do_rd)
        begin
            next_count = count + 1'b1;
        end
        else if (do_rd && !do_wr)
        begin
            next_count = count - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge clk_in)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule : dacrc_fifo

/* File: dacrc_monitor.sv */
// dacrc_monitor: port assertions for dacrc_top
// assumes: bound to every dacrc_top, one clock domain
`timescale 1ns/1ps
module dacrc_monitor (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    // host pins
    input  wire logic        CONVERSION_START_N_IN,
    input  wire logic        INPUT_PAIR_SELECT_IN,
    input  wire logic        CHIP_SELECT_N_IN,
    input  wire logic        READ_N_IN,
    input  wire logic [13:0] CONVERTER_ONE_RAW_IN,
    input  wire logic [13:0] CONVERTER_TWO_RAW_IN,
    // outputs watched
    input  wire logic        BUSY_OUT,
    input  wire logic        TRACK_HOLD_OUT,
    input  wire logic [13:0] DATA_OUT,
    input  wire logic        DATA_OE_OUT,
    input  wire logic        FIFO_OVERFLOW_OUT,
    input  wire logic        MUX_PAIR_B_OUT
);
    default clocking mon_cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic       strobe_low;     // select and read both low
    logic [9:0] busy_len;       // busy cycles so far
    logic [9:0] next_busy_len;  // next busy count
    assign strobe_low = !CHIP_SELECT_N_IN && !READ_N_IN;
    // count cycles with busy high
    always_comb
    begin
        next_busy_len = BUSY_OUT ? busy_len + 10'h001 : 10'h000;
    end
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            busy_len <= 10'h000;
        else
            busy_len <= next_busy_len;
    end
    // strobe seen low long enough to pass the filter
    sequence s_strobe_held;
        $rose(strobe_low) ##1 strobe_low [*3];
    endsequence
    sequence s_strobe_gone;
        $fell(strobe_low) ##1 !strobe_low [*3];
    endsequence
    AST_BUSY_AFTER_START: assert property (
        $fell(CONVERSION_START_N_IN) && !BUSY_OUT |-> ##[1:6] BUSY_OUT)
        else $error("busy did not follow start");
    AST_HOLD_WITH_BUSY: assert property (
        TRACK_HOLD_OUT == BUSY_OUT)
        else $error("hold and busy disagree");
    AST_HOLD_CAUSE: assert property (
        $rose(TRACK_HOLD_OUT) |-> !$past(CONVERSION_START_N_IN, 4))
        else $error("hold without start");
    AST_BUSY_LENGTH: assert property (
        $fell(BUSY_OUT) |-> busy_len == 10'h286)
        else $error("conversion length wrong");
    AST_RESULT_DEADLINE: assert property (
        $fell(CONVERSION_START_N_IN) && !BUSY_OUT |-> ##[1:650] $fell(BUSY_OUT))
        else $error("results later than conversion limit");
    AST_PAIR_FROZEN: assert property (
        TRACK_HOLD_OUT && $past(TRACK_HOLD_OUT) |-> $stable(MUX_PAIR_B_OUT))
        else $error("pair changed during conversion");
    AST_OE_RISE: assert property (
        s_strobe_held |-> ##2 DATA_OE_OUT)
        else $error("bus not driven on read");
    AST_OE_CAUSE: assert property (
        $rose(DATA_OE_OUT) |-> $past(strobe_low, 4))
        else $error("bus driven without read");
    AST_OE_DROP: assert property (
        s_strobe_gone |-> ##2 !DATA_OE_OUT)
        else $error("bus still driven after read");
    AST_DATA_ON_READ: assert property (
        $changed(DATA_OUT) |-> ##1 $rose(DATA_OE_OUT))
        else $error("data changed outside read");
endmodule : dacrc_monitor

bind dacrc_top dacrc_monitor u_dacrc_monitor (
    .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .CONVERSION_START_N_IN(CONVERSION_START_N_IN),
    .INPUT_PAIR_SELECT_IN(INPUT_PAIR_SELECT_IN),
    .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN), .READ_N_IN(READ_N_IN),
    .CONVERTER_ONE_RAW_IN(CONVERTER_ONE_RAW_IN),
    .CONVERTER_TWO_RAW_IN(CONVERTER_TWO_RAW_IN),
    .BUSY_OUT(BUSY_OUT), .TRACK_HOLD_OUT(TRACK_HOLD_OUT),
    .DATA_OUT(DATA_OUT), .DATA_OE_OUT(DATA_OE_OUT),
    .FIFO_OVERFLOW_OUT(FIFO_OVERFLOW_OUT),
    .MUX_PAIR_B_OUT(MUX_PAIR_B_OUT));

/* File: dacrc_host_model.sv */
// dacrc_host_model: host that starts conversions and reads words
// assumes: drives pins at the falling clock edge
`timescale 1ns/1ps
module dacrc_host_model (
    // clock and device outputs
    input  wire logic        clk_in,
    input  wire logic        busy_in,
    input  wire logic [13:0] data_in,
    input  wire logic [13:0] data_alt_in,
    // host control pins
    output logic             start_n_out,
    output logic             pair_select_out,
    output logic             chip_select_n_out,
    output logic             read_n_out
);
    initial
    begin
        start_n_out = 1'b1;
        pair_select_out = 1'b0;
        chip_select_n_out = 1'b1;
        read_n_out = 1'b1;
    end
    // start pulse, optional second pulse while busy, wait for done
    task automatic convert(input logic sel, input bit extra);
        int n;
        n = 0;
        pair_select_out = sel;
        repeat (63) @(negedge clk_in);  // select settles 500 ns
        start_n_out = 1'b0;
        repeat (4) @(negedge clk_in);
        start_n_out = 1'b1;
        while (!busy_in && n < 20)
        begin
            @(negedge clk_in);
            n++;
        end
        if (extra)
        begin
            repeat (100) @(negedge clk_in);
            start_n_out = 1'b0;
            repeat (4) @(negedge clk_in);
            start_n_out = 1'b1;
        end
        while (busy_in && n < 900)      // wait for done
        begin
            @(negedge clk_in);
            n++;
        end
    endtask : convert
    // one read strobe
    task automatic read_word(output logic [13:0] w, output logic [13:0] wa);
        read_n_out = 1'b0;
        repeat (6) @(negedge clk_in);
        w = data_in;
        wa = data_alt_in;
        read_n_out = 1'b1;
        repeat (6) @(negedge clk_in);
    endtask : read_word
    // one select pulse holding two read strobes, then quiet time
    task automatic read_pair(output logic [13:0] a1, a2, u1, u2);
        chip_select_n_out = 1'b0;
        @(negedge clk_in);
        read_word(a1, u1);
        read_word(a2, u2);
        chip_select_n_out = 1'b1;
        repeat (50) @(negedge clk_in);  // 400 ns quiet
    endtask : read_pair
endmodule : dacrc_host_model

/* File: tb.sv */
// tb: self-checking bench for dacrc_top
// assumes: host model drives the pins, bench drives raw codes
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic        sel;
        logic [13:0] r1, r2, e1, e2;
    } dacrc_row_type;
    logic        clk = 1'b0;        // 125 MHz clock
    logic        sys_rst = 1'b1;    // active-high reset
    logic        start_n, pair_sel, cs_n, rd_n;
    logic [13:0] raw_one = 14'h0000;
    logic [13:0] raw_two = 14'h0000;
    logic        busy, hold, oe, ovf, mux;
    logic [13:0] data, data_uni, w1, w2, u1, u2;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;
    // raw codes and the twos complement words they give
    dacrc_row_type rows [3] = '{
        '{1'b0, 14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF},
        '{1'b1, 14'h1FFF, 14'h2000, 14'h3FFF, 14'h0000},
        '{1'b0, 14'h2345, 14'h1ABC, 14'h0345, 14'h3ABC}};
    always #4 clk = ~clk;
    dacrc_top #(.BIPOLAR(1'b1)) u_dacrc_top (
        .CLK_IN(clk), .SYS_RST_IN(sys_rst), .CONVERSION_START_N_IN(start_n),
        .INPUT_PAIR_SELECT_IN(pair_sel), .CHIP_SELECT_N_IN(cs_n),
        .READ_N_IN(rd_n), .CONVERTER_ONE_RAW_IN(raw_one),
        .CONVERTER_TWO_RAW_IN(raw_two), .BUSY_OUT(busy), .TRACK_HOLD_OUT(hold),
        .DATA_OUT(data), .DATA_OE_OUT(oe), .FIFO_OVERFLOW_OUT(ovf), .MUX_PAIR_B_OUT(mux));
    // straight binary twin on the same pins
    dacrc_top #(.BIPOLAR(1'b0)) u_dacrc_top_uni (
        .CLK_IN(clk), .SYS_RST_IN(sys_rst), .CONVERSION_START_N_IN(start_n),
        .INPUT_PAIR_SELECT_IN(pair_sel), .CHIP_SELECT_N_IN(cs_n),
        .READ_N_IN(rd_n), .CONVERTER_ONE_RAW_IN(raw_one),
        .CONVERTER_TWO_RAW_IN(raw_two), .BUSY_OUT(), .TRACK_HOLD_OUT(),
        .DATA_OUT(data_uni), .DATA_OE_OUT(), .FIFO_OVERFLOW_OUT(), .MUX_PAIR_B_OUT());
    dacrc_host_model u_dacrc_host_model (
        .clk_in(clk), .busy_in(busy), .data_in(data), .data_alt_in(data_uni),
        .start_n_out(start_n), .pair_select_out(pair_sel),
        .chip_select_n_out(cs_n), .read_n_out(rd_n));
    // compare and count
    task automatic check(input string name, input logic [13:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            finish_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        // --------------------------------------------------------
        // table of code cases
        // --------------------------------------------------------
        foreach (rows[i])
        begin
            raw_one = rows[i].r1;
            raw_two = rows[i].r2;
            u_dacrc_host_model.convert(rows[i].sel, 1'b0);
            check("busy", {13'h0000, busy}, 14'h0000);
            check("pair", {13'h0000, mux}, {13'h0000, rows[i].sel});
            u_dacrc_host_model.read_pair(w1, w2, u1, u2);
            check("word_one", w1, rows[i].e1);
            check("word_two", w2, rows[i].e2);
            check("uni_one", u1, rows[i].r1);
            check("uni_two", u2, rows[i].r2);
        end
        // second start while busy is dropped, empty reads hold data
        raw_one = 14'h0ABC;
        raw_two = 14'h1DEF;
        u_dacrc_host_model.convert(1'b1, 1'b1);
        check("pair_b", {13'h0000, mux}, 14'h0001);
        u_dacrc_host_model.read_pair(w1, w2, u1, u2);
        check("word_one", w1, 14'h2ABC);
        check("word_two", w2, 14'h3DEF);
        u_dacrc_host_model.read_pair(w1, w2, u1, u2);
        check("empty_one", w1, 14'h3DEF);
        check("empty_two", w2, 14'h3DEF);
        // fill queue plus held word past capacity, then drain oldest first
        for (int k = 0; k < 18; k++)
        begin
            raw_one = 14'(k);
            raw_two = 14'(k) | 14'h0100;
            u_dacrc_host_model.convert(1'b0, 1'b0);
            check("overflow", {13'h0000, ovf}, (k == 17) ? 14'h0001 : 14'h0000);
        end
        for (int k = 0; k < 17; k++)
        begin
            u_dacrc_host_model.read_pair(w1, w2, u1, u2);
            check("queued_one", w1, 14'(k) ^ 14'h2000);
            check("queued_two", w2, (14'(k) | 14'h0100) ^ 14'h2000);
        end
        // reset in mid-run clears every output
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        check("rst_busy", {12'h000, busy, hold}, 14'h0000);
        check("rst_data", data, 14'h0000);
        check("rst_flags", {12'h000, oe, ovf}, 14'h0000);
        check("rst_mux", {13'h0000, mux}, 14'h0000);
        sys_rst = 1'b0;
        finish_test();
    end
endmodule : tb
